//--- include/stpc_pkg.sv
// Purpose: shared constants and types for the stepper translator and PWM control block
// Assumes: 200 MHz system clock, AXI4-Lite register access with 32-bit data
// Notes:   all timing figures are given in their own unit and converted to cycles here
package stpc_pkg;
   // register byte offsets
   localparam logic [3:0] OFF_CTRL   = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_COIL   = 4'h8;

   // control register fields
   localparam int CTRL_EN     = 0;
   localparam int CTRL_SLOPE  = 1;
   localparam int CTRL_RES    = 3;
   localparam int CTRL_DIRBIT = 6;
   localparam int CTRL_POL    = 7;
   localparam int CTRL_DBL    = 8;
   localparam int CTRL_JIT    = 9;
   localparam int CTRL_W      = 10;
   localparam logic [9:0] CTRL_RESET = 10'h000;

   // status register fields
   localparam int STAT_POS   = 0;
   localparam int STAT_FAULT = 7;
   localparam int STAT_FAST  = 9;
   localparam int STAT_DIR   = 11;

   // coil register fields
   localparam int COIL_Y = 16;

   // step resolution codes
   localparam logic [2:0] RES_32   = 3'h0;
   localparam logic [2:0] RES_16   = 3'h1;
   localparam logic [2:0] RES_8    = 3'h2;
   localparam logic [2:0] RES_4    = 3'h3;
   localparam logic [2:0] RES_2    = 3'h4;
   localparam logic [2:0] RES_HSQ  = 3'h5;
   localparam logic [2:0] RES_FULL = 3'h6;
   localparam logic [6:0] FS_ZERO_IDX = 7'h70;  // full step 0* sits at fine index 112
   localparam logic [9:0] MAG_FULL    = 10'h3e8; // 100.0 percent in tenths

   // timing
   localparam int CLK_MHZ       = 200;
   localparam int INTERLOCK_NS  = 100;
   localparam int INTERLOCK_CYC = (INTERLOCK_NS * CLK_MHZ + 999) / 1000;
   localparam int OSC_KHZ       = 4000;
   localparam int OSC_DIV       = CLK_MHZ * 1000 / OSC_KHZ;
   localparam int PWM_HZ        = 22800;
   localparam int PWM_TICKS     = OSC_KHZ * 1000 / PWM_HZ;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // gate drive of one h-bridge
   typedef struct packed {
      logic hs_a;
      logic ls_a;
      logic hs_b;
      logic ls_b;
   } stpc_gate_t;

   // requested coil current
   typedef struct packed {
      logic       neg;
      logic [9:0] mag;
   } stpc_coil_t;

   // pwm phase of one coil
   typedef enum logic [3:0] {
      PH_OFF  = 4'b0001,
      PH_FWD  = 4'b0010,
      PH_SLOW = 4'b0100,
      PH_FAST = 4'b1000
   } stpc_phase_t;
endpackage

//--- src/stpc_core.sv
// Purpose: micro-step translator, pwm current loop and bridge gate control, AXI4-Lite registers
// Assumes: analog comparators, short sensors and back-emf detector arrive asynchronously on pins
// Notes:
`timescale 1ns/1ps
module stpc_core #(
   parameter int PWM_TICKS_P = stpc_pkg::PWM_TICKS,
   parameter int OSC_DIV_P   = stpc_pkg::OSC_DIV
) (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // axi4-lite write
   input  wire logic [3:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   // axi4-lite read
   input  wire logic [3:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   // host pins
   input  wire logic               step_advance_pin,
   input  wire logic               rotation_sense_ctrl,
   // analog sense pins, index 0 coil x, 1 coil y
   input  wire logic [1:0]         current_above_ref,
   input  wire logic [1:0]         driver_overcurrent,
   input  wire logic [1:0]         switch_overvoltage,
   input  wire logic               supply_below_2bemf,
   // bridge side
   output stpc_pkg::stpc_gate_t    gate_x,
   output stpc_pkg::stpc_gate_t    gate_y,
   output logic                    bridge_hiz,
   output logic [1:0]              slope_rate_select,
   output logic [1:0]              driver_current_limit,
   output stpc_pkg::stpc_coil_t    coil_ref_x,
   output stpc_pkg::stpc_coil_t    coil_ref_y
);
   localparam int NSYNC = 8;

   // quarter sine in tenths of a percent, index 0..32
   function automatic logic [9:0] sine_q(input logic [5:0] k);
      logic [9:0] v;
      v = 10'h000;
      unique case (k)
         6'd0:  v = 10'd0;    6'd1:  v = 10'd35;   6'd2:  v = 10'd81;   6'd3:  v = 10'd127;
         6'd4:  v = 10'd174;  6'd5:  v = 10'd221;  6'd6:  v = 10'd267;  6'd7:  v = 10'd314;
         6'd8:  v = 10'd349;  6'd9:  v = 10'd383;  6'd10: v = 10'd430;  6'd11: v = 10'd465;
         6'd12: v = 10'd500;  6'd13: v = 10'd546;  6'd14: v = 10'd581;  6'd15: v = 10'd616;
         6'd16: v = 10'd651;  6'd17: v = 10'd686;  6'd18: v = 10'd721;  6'd19: v = 10'd755;
         6'd20: v = 10'd790;  6'd21: v = 10'd826;  6'd22: v = 10'd849;  6'd23: v = 10'd872;
         6'd24: v = 10'd895;  6'd25: v = 10'd918;  6'd26: v = 10'd930;  6'd27: v = 10'd941;
         6'd28: v = 10'd953;  6'd29: v = 10'd965;  6'd30: v = 10'd977;  6'd31: v = 10'd988;
         default: v = stpc_pkg::MAG_FULL;
      endcase
      return v;
   endfunction

   // coil current of a 1/32 table index; ycoil selects the cosine coil
   function automatic stpc_pkg::stpc_coil_t circ(input logic [6:0] p, input logic ycoil);
      stpc_pkg::stpc_coil_t c;
      logic [5:0]           k;
      logic [5:0]           kc;
      logic [1:0]           q;
      q  = p[6:5];
      k  = {1'b0, p[4:0]};
      kc = 6'd32 - k;
      c.mag = (q[0] ^ ycoil) ? sine_q(kc) : sine_q(k);
      c.neg = ycoil ? (q == 2'd1 || q == 2'd2) : q[1];
      if (c.mag == 10'h000)
         c.neg = 1'b0;
      return c;
   endfunction

   // position mask per resolution
   function automatic logic [6:0] pos_mask(input logic [2:0] m);
      logic [6:0] r;
      unique case (m)
         stpc_pkg::RES_16:   r = 7'h3f;
         stpc_pkg::RES_8:    r = 7'h1f;
         stpc_pkg::RES_4:    r = 7'h0f;
         stpc_pkg::RES_2:    r = 7'h07;
         stpc_pkg::RES_HSQ:  r = 7'h07;
         stpc_pkg::RES_FULL: r = 7'h03;
         default:            r = 7'h7f;
      endcase
      return r;
   endfunction

   // gate pattern for a phase and current sign
   function automatic stpc_pkg::stpc_gate_t gate_of(input stpc_pkg::stpc_phase_t ph, input logic neg);
      stpc_pkg::stpc_gate_t g;
      g = '0;
      unique case (ph)
         stpc_pkg::PH_FWD:  g = neg ? 4'b0110 : 4'b1001;
         stpc_pkg::PH_SLOW: g = 4'b0101;
         stpc_pkg::PH_FAST: g = neg ? 4'b1001 : 4'b0110;
         default:           g = 4'b0000;
      endcase
      return g;
   endfunction

   logic [stpc_pkg::CTRL_W-1:0]  ctrl_r;
   logic [NSYNC-1:0]             s1_r;
   logic [NSYNC-1:0]             s2_r;
   logic [NSYNC-1:0]             s3_r;
   logic [NSYNC-1:0]             flt_r;
   logic                         step_prev_r;
   logic [6:0]                   pos_r;
   logic [2:0]                   mode_r;
   stpc_pkg::stpc_coil_t         tgt_r [2];
   logic [1:0]                   fast_pend_r;
   logic [1:0]                   fault_r;
   stpc_pkg::stpc_phase_t        phase_r [2];
   logic [7:0]                   osc_cnt_r;
   logic                         tick_r;
   logic [8:0]                   pwm_cnt_r;
   logic [8:0]                   period_r;
   logic [7:0]                   lfsr_r;
   logic [1:0]                   half_r [4];
   logic [7:0]                   dead_r [4];
   logic                         aw_full_r;
   logic                         w_full_r;
   logic [3:0]                   aw_addr_r;
   logic [31:0]                  w_data_r;
   logic [3:0]                   w_strb_r;

   // synchronised pin view
   logic [1:0] cmp_above;
   logic [1:0] ocur;
   logic [1:0] ovolt;
   logic       step_lvl;
   logic       dir_lvl;
   logic       bemf_low;
   logic       supply_low_r;
   logic [2:0] bl_r;
   assign step_lvl  = flt_r[0];
   assign dir_lvl   = flt_r[1];
   assign cmp_above = flt_r[3:2];
   assign ocur      = flt_r[5:4];
   assign ovolt     = flt_r[7:6];
   assign bemf_low  = supply_low_r;

   // three-stage pin synchronisers, level accepted when stages two and three agree
   always_ff @(posedge clk_sys)
   begin
      s1_r <= {switch_overvoltage, driver_overcurrent, current_above_ref, rotation_sense_ctrl, step_advance_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < NSYNC; i++)
         if (s2_r[i] == s3_r[i])
            flt_r[i] <= s3_r[i];
      if (rst)
      begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         flt_r <= '0;
      end
   end

   // back-emf detector synchroniser
   always_ff @(posedge clk_sys)
   begin
      bl_r <= {bl_r[1:0], supply_below_2bemf};
      if (bl_r[1] == bl_r[2])
         supply_low_r <= bl_r[2];
      if (rst)
      begin
         bl_r         <= 3'h0;
         supply_low_r <= 1'b0;
      end
   end

   // translator: step edges, direction, mode changes and wrap
   logic step_edge;
   logic dir_dn;
   assign step_edge = ctrl_r[stpc_pkg::CTRL_POL] ? (step_prev_r & ~step_lvl) : (~step_prev_r & step_lvl);
   assign dir_dn    = dir_lvl ^ ctrl_r[stpc_pkg::CTRL_DIRBIT];
   always_ff @(posedge clk_sys)
   begin
      step_prev_r <= step_lvl;
      mode_r      <= ctrl_r[stpc_pkg::CTRL_RES+:3];
      if (mode_r != ctrl_r[stpc_pkg::CTRL_RES+:3])
         pos_r <= 7'h00;
      else if (step_edge)
         pos_r <= (dir_dn ? pos_r - 7'h01 : pos_r + 7'h01) & pos_mask(mode_r);
      if (rst)
      begin
         step_prev_r <= 1'b0;
         mode_r      <= stpc_pkg::RES_32;
         pos_r       <= 7'h00;
      end
   end

   // current tables: circular subset or square half step
   logic [6:0]           fine_idx;
   stpc_pkg::stpc_coil_t want [2];
   always_comb
   begin
      unique case (mode_r)
         stpc_pkg::RES_16:   fine_idx = {pos_r[5:0], 1'b0};
         stpc_pkg::RES_8:    fine_idx = {pos_r[4:0], 2'b0};
         stpc_pkg::RES_4:    fine_idx = {pos_r[3:0], 3'b0};
         stpc_pkg::RES_2:    fine_idx = {pos_r[2:0], 4'b0};
         stpc_pkg::RES_FULL: fine_idx = stpc_pkg::FS_ZERO_IDX + {pos_r[1:0], 5'b0};
         default:            fine_idx = pos_r;
      endcase
      want[0] = circ(fine_idx, 1'b0);
      want[1] = circ(fine_idx, 1'b1);
      if (mode_r == stpc_pkg::RES_HSQ)
      begin
         // odd positions full on both coils, even ones full on one coil
         want[0].mag = (pos_r[2:0] == 3'h0 || pos_r[2:0] == 3'h4) ? 10'h000 : stpc_pkg::MAG_FULL;
         want[0].neg = pos_r[2] && pos_r[1:0] != 2'h0;
         want[1].mag = (pos_r[2:0] == 3'h2 || pos_r[2:0] == 3'h6) ? 10'h000 : stpc_pkg::MAG_FULL;
         want[1].neg = pos_r[2:0] == 3'h3 || pos_r[2:0] == 3'h4 || pos_r[2:0] == 3'h5;
      end
   end

   // requested current and fast decay request on a falling request
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < 2; i++)
      begin
         tgt_r[i] <= want[i];
         if (want[i].mag < tgt_r[i].mag || (want[i].neg != tgt_r[i].neg && tgt_r[i].mag != 10'h000))
            fast_pend_r[i] <= 1'b1;
         else if (phase_r[i] == stpc_pkg::PH_FAST)
            fast_pend_r[i] <= 1'b0;
      end
      if (rst)
      begin
         tgt_r[0]    <= '0;
         tgt_r[1]    <= '0;
         fast_pend_r <= 2'h0;
      end
   end

   // pwm clock: oscillator-rate tick and period counter with double and jitter options
   always_ff @(posedge clk_sys)
   begin
      tick_r <= 1'b0;
      osc_cnt_r <= osc_cnt_r + 8'h01;
      if (osc_cnt_r == 8'(OSC_DIV_P - 1))
      begin
         osc_cnt_r <= 8'h00;
         tick_r    <= 1'b1;
      end
      if (tick_r)
      begin
         pwm_cnt_r <= pwm_cnt_r + 9'h001;
         if (pwm_cnt_r >= period_r)
         begin
            pwm_cnt_r <= 9'h000;
            lfsr_r    <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
            period_r  <= (ctrl_r[stpc_pkg::CTRL_DBL] ? 9'(PWM_TICKS_P / 2) : 9'(PWM_TICKS_P)) - 9'h001
                         + (ctrl_r[stpc_pkg::CTRL_JIT] ? {6'h00, lfsr_r[2:0]} : 9'h000);
         end
      end
      if (rst)
      begin
         osc_cnt_r <= 8'h00;
         tick_r    <= 1'b0;
         pwm_cnt_r <= 9'h000;
         lfsr_r    <= 8'h01;
         period_r  <= 9'(PWM_TICKS_P - 1);
      end
   end

   // per-coil regulation loop
   logic period_start;
   assign period_start = tick_r && pwm_cnt_r >= period_r;
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (!ctrl_r[stpc_pkg::CTRL_EN] || fault_r[i])
            phase_r[i] <= stpc_pkg::PH_OFF;
         else if (period_start)
            phase_r[i] <= (tgt_r[i].mag == 10'h000) ? stpc_pkg::PH_SLOW : stpc_pkg::PH_FWD;
         else if (tick_r)
         begin
            unique case (phase_r[i])
               stpc_pkg::PH_FWD:
                  if (cmp_above[i] && (!bemf_low || pwm_cnt_r > {1'b0, period_r[8:1]}))
                     phase_r[i] <= fast_pend_r[i] ? stpc_pkg::PH_FAST : stpc_pkg::PH_SLOW;
               stpc_pkg::PH_FAST:
                  if (!cmp_above[i])
                     phase_r[i] <= stpc_pkg::PH_SLOW;
               default:
                  phase_r[i] <= phase_r[i];
            endcase
         end
      end
      if (rst)
      begin
         phase_r[0] <= stpc_pkg::PH_OFF;
         phase_r[1] <= stpc_pkg::PH_OFF;
      end
   end

   // short protection: limit on overcurrent, latch off on overvoltage, clear by disabling
   always_ff @(posedge clk_sys)
   begin
      for (int i = 0; i < 2; i++)
      begin
         driver_current_limit[i] <= ocur[i] && phase_r[i] != stpc_pkg::PH_OFF;
         if (driver_current_limit[i] && ovolt[i])
            fault_r[i] <= 1'b1;
         else if (!ctrl_r[stpc_pkg::CTRL_EN])
            fault_r[i] <= 1'b0;
      end
      if (rst)
      begin
         driver_current_limit <= 2'h0;
         fault_r              <= 2'h0;
      end
   end

   // gate drive with dead time per half-bridge, index 2*coil + side
   stpc_pkg::stpc_gate_t dgate [2];
   assign dgate[0] = gate_of(phase_r[0], tgt_r[0].neg);
   assign dgate[1] = gate_of(phase_r[1], tgt_r[1].neg);
   always_ff @(posedge clk_sys)
   begin
      for (int j = 0; j < 4; j++)
      begin
         logic [1:0] d;
         d = j[0] ? {dgate[j/2].hs_b, dgate[j/2].ls_b} : {dgate[j/2].hs_a, dgate[j/2].ls_a};
         if (dead_r[j] != 8'h00)
            dead_r[j] <= dead_r[j] - 8'h01;
         if (d != half_r[j])
         begin
            if (half_r[j] != 2'b00 || d == 2'b00)
            begin
               half_r[j] <= 2'b00;
               dead_r[j] <= 8'(stpc_pkg::INTERLOCK_CYC);
            end
            else if (dead_r[j] == 8'h00)
               half_r[j] <= d;
         end
      end
      if (rst)
         for (int j = 0; j < 4; j++)
         begin
            half_r[j] <= 2'b00;
            dead_r[j] <= 8'h00;
         end
   end

   // registered bridge and reference outputs
   always_ff @(posedge clk_sys)
   begin
      gate_x            <= {half_r[0], half_r[1]};
      gate_y            <= {half_r[2], half_r[3]};
      bridge_hiz        <= ~ctrl_r[stpc_pkg::CTRL_EN];
      slope_rate_select <= ctrl_r[stpc_pkg::CTRL_SLOPE+:2];
      coil_ref_x        <= tgt_r[0];
      coil_ref_y        <= tgt_r[1];
      if (rst)
      begin
         gate_x            <= '0;
         gate_y            <= '0;
         bridge_hiz        <= 1'b1;
         slope_rate_select <= 2'h0;
         coil_ref_x        <= '0;
         coil_ref_y        <= '0;
      end
   end

   // axi write: address and data taken in either order, answered once both are held
   logic wr_go;
   assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
   always_ff @(posedge clk_sys)
   begin
      if (s_axi_awvalid && s_axi_awready)
      begin
         aw_full_r     <= 1'b1;
         s_axi_awready <= 1'b0; // ready kept in its own flop
         aw_addr_r     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         w_full_r     <= 1'b1;
         s_axi_wready <= 1'b0;
         w_data_r     <= s_axi_wdata;
         w_strb_r     <= s_axi_wstrb;
      end
      if (wr_go)
      begin
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b1;
         s_axi_bresp   <= (aw_addr_r[3:2] <= 2'h2) ? stpc_pkg::RESP_OKAY : stpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
      if (rst)
      begin
         aw_full_r     <= 1'b0;
         w_full_r      <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_addr_r     <= 4'h0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 4'h0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= stpc_pkg::RESP_OKAY;
      end
   end

   // control register, byte lanes 0 and 1
   always_ff @(posedge clk_sys)
   begin
      if (wr_go && {aw_addr_r[3:2], 2'b00} == stpc_pkg::OFF_CTRL)
      begin
         if (w_strb_r[0])
            ctrl_r[7:0] <= w_data_r[7:0];
         if (w_strb_r[1])
            ctrl_r[9:8] <= w_data_r[9:8];
      end
      if (rst)
         ctrl_r <= stpc_pkg::CTRL_RESET;
   end

   // axi read: one-cycle answer, held until taken
   logic [31:0] rd_mux;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case ({s_axi_araddr[3:2], 2'b00})
         stpc_pkg::OFF_CTRL:   rd_mux[stpc_pkg::CTRL_W-1:0] = ctrl_r;
         stpc_pkg::OFF_STATUS:
         begin
            rd_mux[stpc_pkg::STAT_POS+:7]   = pos_r;
            rd_mux[stpc_pkg::STAT_FAULT+:2] = fault_r;
            rd_mux[stpc_pkg::STAT_FAST+:2]  = {phase_r[1] == stpc_pkg::PH_FAST, phase_r[0] == stpc_pkg::PH_FAST};
            rd_mux[stpc_pkg::STAT_DIR]      = dir_dn;
         end
         stpc_pkg::OFF_COIL:
         begin
            rd_mux[10:0]                    = tgt_r[0];
            rd_mux[stpc_pkg::COIL_Y+:11]    = tgt_r[1];
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_sys)
   begin
      if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid  <= 1'b1;
         s_axi_arready <= 1'b0; // no new address while the answer waits
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= (s_axi_araddr[3:2] <= 2'h2) ? stpc_pkg::RESP_OKAY : stpc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
      if (rst)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= stpc_pkg::RESP_OKAY;
      end
   end
endmodule

//--- testbench/stpc_core_props.sv
// Purpose: port checks for the translator and bridge block
// Assumes: one clock domain, synchronous reset
// Notes:   attached by the bind below
`timescale 1ns/1ps
module stpc_core_props (
   // clock and reset
   input logic                 clk_sys,
   input logic                 rst,
   // bus answers
   input logic                 s_axi_bvalid,
   input logic                 s_axi_bready,
   input logic                 s_axi_rvalid,
   input logic                 s_axi_rready,
   input logic [31:0]          s_axi_rdata,
   input logic                 s_axi_arready,
   // bridge side
   input stpc_pkg::stpc_gate_t gate_x,
   input stpc_pkg::stpc_gate_t gate_y,
   input logic                 bridge_hiz,
   input stpc_pkg::stpc_coil_t coil_ref_x,
   input stpc_pkg::stpc_coil_t coil_ref_y
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // gate relations and coil request bound
   a_hiz_gates_off: assert property (bridge_hiz [*3] |-> gate_x == 4'h0 && gate_y == 4'h0)
      else $error("gate on while bridges off");
   a_shoot_x: assert property (!(gate_x.hs_a && gate_x.ls_a) && !(gate_x.hs_b && gate_x.ls_b))
      else $error("coil x half-bridge shoot-through");
   a_shoot_y: assert property (!(gate_y.hs_a && gate_y.ls_a) && !(gate_y.hs_b && gate_y.ls_b))
      else $error("coil y half-bridge shoot-through");
   a_dead_x: assert property ($fell(gate_x.hs_a) |-> !gate_x.ls_a [*8])
      else $error("coil x dead time too short");
   a_coil_bound: assert property (coil_ref_x.mag <= stpc_pkg::MAG_FULL && coil_ref_y.mag <= stpc_pkg::MAG_FULL)
      else $error("coil request above full scale");
   // bus answers hold
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer waits");
   c_pwm: cover property ($rose(gate_x.hs_a));
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind stpc_core stpc_core_props u_props (.clk_sys, .rst, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_arready, .gate_x, .gate_y, .bridge_hiz, .coil_ref_x, .coil_ref_y);

//--- testbench/stpc_host_pins.sv
// Purpose: host side of the step and direction pins
// Assumes: edges spaced well beyond the pin filter
// Notes:   driven through its tasks
`timescale 1ns/1ps
module stpc_host_pins (
   // clock
   input logic  clk_sys,
   // pins toward the device
   output logic step_advance_pin,
   output logic rotation_sense_ctrl
);
   // idle levels
   initial
   begin
      step_advance_pin = 1'b0;
      rotation_sense_ctrl = 1'b0;
   end
   // one edge on the step pin, then settle
   task automatic half();
      @(posedge clk_sys);
      step_advance_pin <= ~step_advance_pin;
      repeat (12) @(posedge clk_sys);
   endtask
   // rotation sense level, away from step edges
   task automatic dir(input logic v);
      @(posedge clk_sys);
      rotation_sense_ctrl <= v;
      repeat (12) @(posedge clk_sys);
   endtask
endmodule

//--- testbench/stpc_core_tb.sv
// Purpose: self-checking bench for the translator block
// Assumes: shortened pwm counts
// Notes:   bus access through wr and rd
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module stpc_core_tb;
   logic                 clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, bridge_hiz;
   logic                 supply_below_2bemf, step_advance_pin, rotation_sense_ctrl;
   logic [3:0]           s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0]          s_axi_wdata, s_axi_rdata, rdv, seed;
   logic [1:0]           s_axi_bresp, s_axi_rresp, wrp, rrp, slope_rate_select, driver_current_limit;
   logic [1:0]           current_above_ref, driver_overcurrent, switch_overvoltage;
   stpc_pkg::stpc_gate_t gate_x, gate_y;
   stpc_pkg::stpc_coil_t coil_ref_x, coil_ref_y;
   logic [7:0]           cnt = 8'h0;
   logic [2:0]           m;
   int                   error_cnt = 0, n_checks = 0, i;
   stpc_core #(.PWM_TICKS_P(20), .OSC_DIV_P(4)) u_dut (.*);
   stpc_host_pins u_host (.clk_sys(clk_sys), .step_advance_pin(step_advance_pin),
      .rotation_sense_ctrl(rotation_sense_ctrl));
   // comparator pattern keeps the current loop switching
   always @(posedge clk_sys) cnt <= cnt + 8'h1;
   assign current_above_ref = cnt[6:5];
   // clock
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // watchdog
   initial
   begin
      #100000;
      error_cnt++;
      summarize();
   end
   // expected coil pair for a mode and position
   function automatic logic [21:0] ex(input logic [2:0] mo, input int p);
      int k;
      k = (mo == stpc_pkg::RES_FULL) ? (112 + 32 * p) % 128 : p << mo;
      if (mo == stpc_pkg::RES_HSQ)
         return {(p % 4) ? {p > 4, 10'h3e8} : 11'h0, (p % 4 == 2) ? 11'h0 : {p > 2 && p < 6, 10'h3e8}};
      return (k == 16) ? {11'h28b, 11'h28b} : (k == 112) ? {11'h68b, 11'h28b} : {11'h0, 11'h3e8};
   endfunction
   // bus write, address and data offered together
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic ta = 1'b0, tw = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
      while (!(ta && tw))
      begin
         @(negedge clk_sys);
         {ta, tw} = {ta | s_axi_awready, tw | s_axi_wready};
         @(posedge clk_sys);
         {s_axi_awvalid, s_axi_wvalid} <= ~{ta, tw};
      end
      // late bready lets the response wait once
      repeat (2) @(posedge clk_sys);
      s_axi_bready <= 1'b1;
      do @(negedge clk_sys); while (!s_axi_bvalid);
      wrp = s_axi_bresp;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   // bus read
   task automatic rd(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(negedge clk_sys); while (!s_axi_arready);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      @(posedge clk_sys);
      s_axi_rready <= 1'b1;
      do @(negedge clk_sys); while (!s_axi_rvalid);
      {rrp, rdv} = {s_axi_rresp, s_axi_rdata};
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic summarize();
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence
   initial
   begin
      seed = 32'h713ee520;
      {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {40'h0, 4'hf};
      {driver_overcurrent, switch_overvoltage, supply_below_2bemf} = 5'h0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK({coil_ref_x, coil_ref_y, bridge_hiz}, {ex(0, 0), 1'b1})
      for (i = 0; i < 8; i++)
      begin
         m = (i < 4) ? 3'(i) : 3'($random(seed));
         wr(4'h0, {22'h0, m[2:1], 5'h0, m[1:0], 1'b1});
         `CHK({slope_rate_select, bridge_hiz}, {m[1:0], 1'b0})
      end
      wr(4'h0, 32'h0);
      repeat (3) @(posedge clk_sys);
      `CHK(bridge_hiz, 1'b1)
      for (i = 0; i < 7; i++)
      begin
         m = 3'(i);
         wr(4'h0, {26'h0, m, 3'h1});
         repeat (100) @(posedge clk_sys);
         `CHK({coil_ref_x, coil_ref_y}, ex(m, 0))
      end
      repeat (2) u_host.half();
      `CHK({coil_ref_x, coil_ref_y}, ex(stpc_pkg::RES_FULL, 1))
      wr(4'h0, 32'ha9);
      u_host.half();
      `CHK({coil_ref_x, coil_ref_y}, ex(stpc_pkg::RES_HSQ, 0))
      u_host.half();
      `CHK({coil_ref_x, coil_ref_y}, ex(stpc_pkg::RES_HSQ, 1))
      u_host.dir(1'b1);
      repeat (4) u_host.half();
      `CHK({coil_ref_x, coil_ref_y}, ex(stpc_pkg::RES_HSQ, 7))
      wr(4'hc, 32'hffffffff);
      rd(4'h0);
      `CHK({wrp, rdv}, {stpc_pkg::RESP_SLVERR, 32'ha9})
      rd(4'hc);
      `CHK({rrp, rdv}, {stpc_pkg::RESP_SLVERR, 32'h0})
      // short on coil x: both limit, then overvoltage latches x off
      driver_overcurrent <= 2'h3;
      repeat (10) @(posedge clk_sys);
      `CHK(driver_current_limit, 2'h3)
      switch_overvoltage <= 2'h1;
      repeat (10) @(posedge clk_sys);
      rd(4'h4);
      `CHK({rdv[stpc_pkg::STAT_FAULT+:2], driver_current_limit, gate_x}, {4'h6, 4'h0})
      {driver_overcurrent, switch_overvoltage} <= 4'h0;
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK({coil_ref_x, coil_ref_y, bridge_hiz}, {ex(0, 0), 1'b1})
      summarize();
   end
endmodule
